// File: logic/dhi_pkg.sv
// Shared constants and carrier types of the display host interface port
package dhi_pkg;

    // ==========================================================
    // Bus mode strap codes
    localparam logic [1:0] DHI_MODE_8080 = 2'h0; // Intel-style strobes
    localparam logic [1:0] DHI_MODE_6800 = 2'h1; // Motorola-style enable
    localparam logic [1:0] DHI_MODE_SER = 2'h2; // Write-only 4-wire serial
    localparam logic [1:0] DHI_MODE_I2C = 2'h3; // Two-wire slave

    // ==========================================================
    // Pin roles in the low data lines
    localparam int DHI_PIN_CLK = 0; // Serial or two-wire clock
    localparam int DHI_PIN_SIN = 1; // Serial data or two-wire data in
    localparam int DHI_PIN_ACK = 2; // Two-wire acknowledge out

    // ==========================================================
    // Byte framing and two-wire address
    localparam logic [3:0] DHI_BYTE_LAST = 4'h7; // Index of eighth bit
    localparam logic [3:0] DHI_ACK_SLOT = 4'h8; // Ninth clock of a byte
    localparam logic [2:0] DHI_SER_LAST = 3'h7; // Eighth serial clock
    localparam logic [5:0] DHI_I2C_ADDR_HI = 6'h1E; // Upper six address bits
    localparam int DHI_CTRL_CONT = 7; // Continuation flag position
    localparam int DHI_CTRL_DC = 6; // Data/command flag position

    // ==========================================================
    // Reset values
    localparam logic [7:0] DHI_BYTE_RESET = 8'h00; // Shift and read latches
    localparam int DHI_COL_RESET = 0; // Column pointer after reset

    // Pins as seen by the core after synchronising
    typedef struct packed {
        logic [1:0] mode;
        logic form;
        logic cs_n;
        logic e_rd_n;
        logic rw_wr_n;
        logic dc;
        logic [7:0] d;
    } dhi_pins_type;

    // A byte handed from the serial link to the core
    typedef struct packed {
        logic is_data;
        logic [7:0] value;
    } dhi_byte_type;

    // Two-wire slave sequencer states
    typedef enum logic [2:0] {
        DHI_I2C_IDLE,
        DHI_I2C_ADDR,
        DHI_I2C_CTRL,
        DHI_I2C_DATA,
        DHI_I2C_READ,
        DHI_I2C_SKIP
    } dhi_i2c_state_type;

endpackage

// File: logic/dhi_host_port.sv
// Host access port of a display controller: parallel, serial and two-wire
//
// What this block does
// - Low data pins reused per strapped bus mode
// - 6800: read/write low writes, high reads
// - Data/command low is command or status
// - 6800: latch on enable fall, chip select low
// - 8080 form one: read ends on strobe rise
// - 8080 form one: write taken on strobe rise
// - 8080 form two: latch on chip select rise
// - Serial: shift eight bits, MSB first, rising
// - Serial: eighth clock samples select, delivers byte
// - Serial link is write only
// - Two-wire address 0111100 or 0111101 by strap
// - Bit after address: one reads, zero writes
// - Acknowledge address, control and data bytes
// - Detect start and stop conditions
// - Control byte: continuation, select, six zeros
// - Continuation zero: rest are data bytes
// - Select zero to commands, one to RAM
// - Column pointer steps after each data write
// - Data input wired; acknowledge pin optional
// - Reset clears the serial shift register
// - Reset sets column counter to zero
`timescale 1ns/1ps

module dhi_host_port #(
    parameter int COL_W = 8 // Width of the display RAM column pointer
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic ser_clk_i,
    input wire logic [1:0] bus_mode_i,
    input wire logic cs_latch_form_i,
    input wire logic cs_n_i,
    input wire logic e_rd_n_i,
    input wire logic rw_wr_n_i,
    input wire logic dc_i,
    input wire logic [7:0] d_i,
    output logic [7:0] d_o,
    output logic [7:0] d_oe_o,
    input wire logic [7:0] status_i,
    input wire logic [7:0] ram_rd_data_i,
    output logic [7:0] wr_byte_o,
    output logic cmd_wr_o,
    output logic ram_wr_o,
    output logic [COL_W-1:0] ram_addr_o,
    output logic [COL_W-1:0] col_addr_o
);

    // ==========================================================
    // Elaboration check
    generate
        if (COL_W < 1 || COL_W > 16) begin : g_bad_width
            $error("COL_W must lie between 1 and 16");
        end
    endgenerate

    // ==========================================================
    // Serial link domain, clocked by the host's serial clock
    // Shift state clears while deselected or in reset; the clock stands
    // still between frames, so the clear cannot wait for an edge.
    typedef struct packed {
        logic [2:0] cnt; // Bits taken in this byte
        logic [7:0] shreg; // Byte being assembled
    } dhi_shift_type;

    // Handoff state clears only in reset, so a deselect never fakes an edge
    typedef struct packed {
        dhi_pkg::dhi_byte_type hold; // Last complete byte
        logic tog; // Flips once per delivered byte
    } dhi_hand_type;

    dhi_shift_type lnk; // Shift registers
    dhi_shift_type next_lnk; // Their next value
    dhi_hand_type hnd; // Handoff registers
    dhi_hand_type next_hnd; // Their next value
    logic lnk_clr; // Asynchronous clear of the shifter
    logic [7:0] ser_byte; // Byte including the bit on this edge

    assign lnk_clr = ~rst_n_i | cs_n_i;

    // Serial shifter and byte handoff
    always_comb begin
        next_lnk = lnk;
        next_hnd = hnd;
        ser_byte = {lnk.shreg[6:0], d_i[dhi_pkg::DHI_PIN_SIN]};
        next_lnk.shreg = ser_byte;
        next_lnk.cnt = lnk.cnt + 3'h1;
        // Eighth edge: sample select and hand the byte on
        if (lnk.cnt == dhi_pkg::DHI_SER_LAST) begin
            next_hnd.hold.is_data = dc_i;
            next_hnd.hold.value = ser_byte;
            next_hnd.tog = ~hnd.tog;
        end
    end

    // Shifter flops
    always_ff @(posedge ser_clk_i or posedge lnk_clr) begin
        if (lnk_clr) begin
            lnk <= '0;
        end else begin
            lnk <= next_lnk;
        end
    end

    // Handoff flops; the hold word is stable long before the toggle is seen
    always_ff @(posedge ser_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hnd <= '0;
        end else begin
            hnd <= next_hnd;
        end
    end

    // ==========================================================
    // Core domain state
    typedef struct packed {
        dhi_pkg::dhi_pins_type p1; // First sync stage, read only by p2
        dhi_pkg::dhi_pins_type p2; // Settled pin levels
        dhi_pkg::dhi_pins_type p3; // Levels one cycle earlier
        logic t1; // Toggle sync, first stage
        logic t2; // Toggle sync, settled
        logic t3; // Toggle, one cycle earlier
        logic strap_done; // Straps taken after reset
        logic [1:0] live; // Sync stages refilled since reset
        logic [1:0] mode; // Latched bus mode
        logic form; // 8080 chip-select latch form
        logic strap_lsb; // Latched two-wire address bit
        logic [7:0] rd_buf; // Pipelined display read data
        logic [7:0] dout; // Data pins driven on reads
        logic [7:0] doe; // Data pin enables
        dhi_pkg::dhi_i2c_state_type i2c_st; // Two-wire sequencer
        logic [3:0] bit_cnt; // Two-wire bit position
        logic [7:0] i2c_sh; // Two-wire shift register
        logic repeat_ctrl_flag; // Control byte continuation
        logic cmd_data_flag; // Control byte data select
        logic sda_low; // Acknowledge or read bit driven low
        logic nack; // Host refused the last read byte
        logic rd_sent; // A read byte has gone out
        logic [7:0] wr_byte; // Delivered byte
        logic cmd_wr; // Command strobe
        logic ram_wr; // Display RAM strobe
        logic [COL_W-1:0] ram_addr; // Address of the RAM write
        logic [COL_W-1:0] col; // Column pointer
    } dhi_core_type;

    dhi_core_type st; // Registered state
    dhi_core_type next_st; // Next state
    dhi_pkg::dhi_pins_type pins; // Raw pin bundle

    assign pins = '{mode: bus_mode_i, form: cs_latch_form_i, cs_n: cs_n_i,
                    e_rd_n: e_rd_n_i, rw_wr_n: rw_wr_n_i, dc: dc_i, d: d_i};

    // Decoded events, from settled levels only
    logic rd_act; // Read strobe asserted now
    logic rd_act_prev; // And one cycle earlier
    logic rd_end; // A read access completes
    logic wr_end; // A write access completes
    logic scl; // Two-wire clock
    logic scl_prev;
    logic sda; // Two-wire data
    logic sda_prev;
    logic i2c_start;
    logic i2c_stop;
    logic scl_rise;
    logic scl_fall;
    logic dlv; // A byte is delivered this cycle
    logic dlv_data; // It goes to display RAM
    logic [7:0] dlv_byte; // Its value

    // Main sequencing for all four bus modes
    always_comb begin
        next_st = st;
        next_st.p1 = pins;
        next_st.p2 = st.p1;
        next_st.p3 = st.p2;
        next_st.t1 = hnd.tog;
        next_st.t2 = st.t1;
        next_st.t3 = st.t2;
        next_st.cmd_wr = 1'b0;
        next_st.ram_wr = 1'b0;
        dlv = 1'b0;
        dlv_data = 1'b0;
        dlv_byte = st.p3.d;
        rd_act = 1'b0;
        rd_act_prev = 1'b0;
        rd_end = 1'b0;
        wr_end = 1'b0;
        scl = st.p2.d[dhi_pkg::DHI_PIN_CLK];
        scl_prev = st.p3.d[dhi_pkg::DHI_PIN_CLK];
        sda = st.p2.d[dhi_pkg::DHI_PIN_SIN];
        sda_prev = st.p3.d[dhi_pkg::DHI_PIN_SIN];
        i2c_start = scl & scl_prev & sda_prev & ~sda;
        i2c_stop = scl & scl_prev & ~sda_prev & sda;
        scl_rise = scl & ~scl_prev;
        scl_fall = ~scl & scl_prev;

        // Straps are taken once, when both sync stages hold live pin levels
        next_st.live = {st.live[0], 1'b1};
        if (!st.strap_done && st.live[1]) begin
            next_st.strap_done = 1'b1;
            next_st.mode = st.p2.mode;
            next_st.form = st.p2.form;
            next_st.strap_lsb = st.p2.dc;
        end

        unique case (st.mode)
            dhi_pkg::DHI_MODE_6800: begin
                // Enable high with read selected drives the bus
                rd_act = ~st.p2.cs_n & st.p2.e_rd_n & st.p2.rw_wr_n;
                rd_act_prev = ~st.p3.cs_n & st.p3.e_rd_n & st.p3.rw_wr_n;
                // Enable falling edge with chip select still low
                if (st.p2.e_rd_n == 1'b0 && st.p3.e_rd_n == 1'b1 && !st.p3.cs_n) begin
                    rd_end = st.p3.rw_wr_n;
                    wr_end = ~st.p3.rw_wr_n;
                end
            end
            dhi_pkg::DHI_MODE_8080: begin
                rd_act = ~st.p2.cs_n & ~st.p2.e_rd_n;
                rd_act_prev = ~st.p3.cs_n & ~st.p3.e_rd_n;
                if (st.form) begin
                    // Strobes held steady, chip select rising latches
                    if (st.p2.cs_n && !st.p3.cs_n) begin
                        rd_end = ~st.p3.e_rd_n;
                        wr_end = ~st.p3.rw_wr_n;
                    end
                end else begin
                    // Strobe rising edges while chip select is low
                    rd_end = st.p2.e_rd_n & ~st.p3.e_rd_n & ~st.p3.cs_n;
                    wr_end = st.p2.rw_wr_n & ~st.p3.rw_wr_n & ~st.p3.cs_n;
                end
            end
            dhi_pkg::DHI_MODE_SER: begin
                // Serial never drives the bus; only handed bytes arrive
                if (st.t2 != st.t3) begin
                    dlv = 1'b1;
                    dlv_data = hnd.hold.is_data;
                    dlv_byte = hnd.hold.value;
                end
            end
            dhi_pkg::DHI_MODE_I2C: begin
                if (i2c_start) begin
                    next_st.i2c_st = dhi_pkg::DHI_I2C_ADDR;
                    next_st.bit_cnt = 4'hF; // First fall after start steps to bit zero
                    next_st.sda_low = 1'b0;
                end else if (i2c_stop) begin
                    next_st.i2c_st = dhi_pkg::DHI_I2C_IDLE;
                    next_st.sda_low = 1'b0;
                end else if (st.i2c_st != dhi_pkg::DHI_I2C_IDLE &&
                             st.i2c_st != dhi_pkg::DHI_I2C_SKIP) begin
                    // Data is sampled while the clock is high
                    if (scl_rise) begin
                        if (st.bit_cnt < dhi_pkg::DHI_ACK_SLOT &&
                            st.i2c_st != dhi_pkg::DHI_I2C_READ) begin
                            next_st.i2c_sh = {st.i2c_sh[6:0], sda};
                        end else if (st.bit_cnt == dhi_pkg::DHI_ACK_SLOT &&
                                     st.rd_sent) begin
                            next_st.nack = sda;
                        end
                    end
                    // All driving changes only while the clock is low
                    if (scl_fall) begin
                        if (st.bit_cnt == dhi_pkg::DHI_BYTE_LAST) begin
                            next_st.bit_cnt = dhi_pkg::DHI_ACK_SLOT;
                            unique case (st.i2c_st)
                                dhi_pkg::DHI_I2C_ADDR: begin
                                    if (st.i2c_sh[7:1] ==
                                        {dhi_pkg::DHI_I2C_ADDR_HI, st.strap_lsb}) begin
                                        next_st.sda_low = 1'b1;
                                        next_st.rd_sent = 1'b0;
                                        next_st.i2c_st = st.i2c_sh[0] ?
                                            dhi_pkg::DHI_I2C_READ :
                                            dhi_pkg::DHI_I2C_CTRL;
                                    end else begin
                                        // Other slaves' traffic is ignored
                                        next_st.i2c_st = dhi_pkg::DHI_I2C_SKIP;
                                    end
                                end
                                dhi_pkg::DHI_I2C_CTRL: begin
                                    // Low six bits carry nothing and are ignored
                                    next_st.repeat_ctrl_flag =
                                        st.i2c_sh[dhi_pkg::DHI_CTRL_CONT];
                                    next_st.cmd_data_flag =
                                        st.i2c_sh[dhi_pkg::DHI_CTRL_DC];
                                    next_st.sda_low = 1'b1;
                                    next_st.i2c_st = dhi_pkg::DHI_I2C_DATA;
                                end
                                dhi_pkg::DHI_I2C_DATA: begin
                                    dlv = 1'b1;
                                    dlv_data = st.cmd_data_flag;
                                    dlv_byte = st.i2c_sh;
                                    next_st.sda_low = 1'b1;
                                    // Stay on data, or expect a new control byte
                                    next_st.i2c_st = st.repeat_ctrl_flag ?
                                        dhi_pkg::DHI_I2C_CTRL :
                                        dhi_pkg::DHI_I2C_DATA;
                                end
                                dhi_pkg::DHI_I2C_READ: begin
                                    next_st.sda_low = 1'b0; // Host acknowledges
                                end
                                default: begin
                                    next_st.sda_low = 1'b0;
                                end
                            endcase
                        end else if (st.bit_cnt == dhi_pkg::DHI_ACK_SLOT) begin
                            next_st.bit_cnt = 4'h0;
                            next_st.sda_low = 1'b0;
                            if (st.i2c_st == dhi_pkg::DHI_I2C_READ) begin
                                if (st.rd_sent && st.nack) begin
                                    next_st.i2c_st = dhi_pkg::DHI_I2C_SKIP;
                                end else begin
                                    // Reads return the status byte, MSB first
                                    next_st.i2c_sh = status_i;
                                    next_st.sda_low = ~status_i[7];
                                    next_st.rd_sent = 1'b1;
                                end
                            end
                        end else begin
                            next_st.bit_cnt = st.bit_cnt + 4'h1;
                            if (st.i2c_st == dhi_pkg::DHI_I2C_READ) begin
                                next_st.i2c_sh = {st.i2c_sh[6:0], 1'b0};
                                next_st.sda_low = ~st.i2c_sh[6];
                            end
                        end
                    end
                end
            end
        endcase
        if (!st.strap_done) begin // Sync stages still hold reset levels, not strobes
            {rd_act, rd_end, wr_end} = 3'h0;
        end

        // Parallel reads: status at once, display data through a pipeline
        if (rd_act && !rd_act_prev) begin
            next_st.dout = st.p2.dc ? st.rd_buf : status_i;
        end
        // The first display read shows stale data; the host reads once more
        if (rd_end && st.p3.dc) begin
            next_st.rd_buf = ram_rd_data_i;
        end
        if (wr_end) begin
            dlv = 1'b1;
            dlv_data = st.p3.dc;
            dlv_byte = st.p3.d;
        end

        // Pin enables: whole bus on parallel reads, open-drain ack in two-wire
        next_st.doe = 8'h00;
        if (rd_act && (st.mode == dhi_pkg::DHI_MODE_6800 ||
                       st.mode == dhi_pkg::DHI_MODE_8080)) begin
            next_st.doe = 8'hFF;
        end
        if (st.mode == dhi_pkg::DHI_MODE_I2C) begin
            next_st.doe[dhi_pkg::DHI_PIN_ACK] = next_st.sda_low;
            next_st.dout = 8'h00;
        end

        // One delivery point for every mode
        if (dlv) begin
            next_st.wr_byte = dlv_byte;
            next_st.cmd_wr = ~dlv_data;
            next_st.ram_wr = dlv_data;
            next_st.ram_addr = st.col;
            if (dlv_data) begin
                next_st.col = st.col + {{(COL_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Core registers; synchronous reset
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            st <= '0;
            st.rd_buf <= dhi_pkg::DHI_BYTE_RESET;
            st.i2c_sh <= dhi_pkg::DHI_BYTE_RESET;
            st.i2c_st <= dhi_pkg::DHI_I2C_IDLE;
            st.col <= COL_W'(dhi_pkg::DHI_COL_RESET);
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs, all from registers
    assign d_o = st.dout;
    assign d_oe_o = st.doe;
    assign wr_byte_o = st.wr_byte;
    assign cmd_wr_o = st.cmd_wr;
    assign ram_wr_o = st.ram_wr;
    assign ram_addr_o = st.ram_addr;
    assign col_addr_o = st.col;

endmodule

// File: dv/dhi_host_port_monitor.sv
// Checker of the display host port, bound to its ports
`timescale 1ns/1ps
module dhi_host_port_monitor #(
    parameter int COL_W = 8 // Column pointer width
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [1:0] bus_mode_i,
    input wire logic cs_n_i,
    input wire logic e_rd_n_i,
    input wire logic rw_wr_n_i,
    input wire logic dc_i,
    input wire logic [7:0] status_i,
    input wire logic [7:0] d_o,
    input wire logic [7:0] d_oe_o,
    input wire logic cmd_wr_o,
    input wire logic ram_wr_o,
    input wire logic [COL_W-1:0] ram_addr_o,
    input wire logic [COL_W-1:0] col_addr_o
);
    // ==========================================================
    // Clocking and reset
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // ==========================================================
    // Strobe fall of a 6800 write, then a delivery past the sync flops
    sequence s_wr68(sel);
        bus_mode_i == dhi_pkg::DHI_MODE_6800 && !cs_n_i && !rw_wr_n_i
            && dc_i == sel && $fell(e_rd_n_i);
    endsequence
    // Window is wide because the pin edge lands at any phase
    sequence s_late(sig);
        ##[2:6] sig;
    endsequence
    // ==========================================================
    // Assertions
    a_data_to_ram: assert property (s_wr68(1'b1) |-> s_late(ram_wr_o))
        else $error("data write not delivered to RAM");
    a_cmd_to_dec: assert property (s_wr68(1'b0) |-> s_late(cmd_wr_o))
        else $error("command write not delivered");
    a_pulse_single: assert property ((cmd_wr_o || ram_wr_o) |=> !(cmd_wr_o || ram_wr_o))
        else $error("delivery strobe longer than one cycle");
    a_col_step: assert property (ram_wr_o |-> col_addr_o == COL_W'(ram_addr_o + 1'b1))
        else $error("column pointer did not step past the written column");
    a_col_hold: assert property (!ram_wr_o |-> $stable(col_addr_o))
        else $error("column pointer moved without a data write");
    a_reset_zero: assert property (disable iff (1'b0) !rst_n_i |=> col_addr_o == '0)
        else $error("column pointer not cleared by reset");
    a_ser_no_drive: assert property (bus_mode_i == dhi_pkg::DHI_MODE_SER |-> d_oe_o == 8'h00)
        else $error("data pins driven in serial mode");
    a_status_read: assert property (d_oe_o == 8'hFF && !dc_i |-> d_o == status_i)
        else $error("command-side read did not return status");
endmodule
bind dhi_host_port dhi_host_port_monitor #(.COL_W(COL_W)) u_monitor (
    .core_clk_i, .rst_n_i, .bus_mode_i, .cs_n_i, .e_rd_n_i, .rw_wr_n_i, .dc_i,
    .status_i, .d_o, .d_oe_o, .cmd_wr_o, .ram_wr_o, .ram_addr_o, .col_addr_o
);

// File: dv/dhi_host_model.sv
// Host controller model driving the parallel, serial and two-wire pins
`timescale 1ns/1ps
module dhi_host_model (
    input wire logic core_clk_i,
    input wire logic [7:0] bus_i,
    output logic cs_n_o,
    output logic e_o,
    output logic rw_o,
    output logic dc_o,
    output logic [7:0] d_o,
    output logic ser_clk_o
);
    // ==========================================================
    // Idle pins: deselected, link clock still
    initial begin
        cs_n_o = 1'b1;
        e_o = 1'b0;
        rw_o = 1'b0;
        dc_o = 1'b0;
        d_o = 8'h00;
        ser_clk_o = 1'b0;
    end
    // One bus phase; six cycles cover the two sync flops on both sides
    task automatic step(input logic cs, e, rw, dc, input logic [7:0] d, output logic [7:0] q);
        @(posedge core_clk_i);
        #1;
        cs_n_o = cs;
        e_o = e;
        rw_o = rw;
        dc_o = dc;
        d_o = d;
        repeat (6) @(posedge core_clk_i);
        q = bus_i;
    endtask
    // One serial byte; clock only runs inside the frame
    task automatic ser_byte(input logic dc, input logic [7:0] b);
        @(posedge core_clk_i);
        #1;
        cs_n_o = 1'b0;
        dc_o = dc;
        d_o = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            d_o[1] = b[i];
            #7.5 ser_clk_o = 1'b1;
            #7.5 ser_clk_o = 1'b0;
        end
        #20 cs_n_o = 1'b1;
    endtask
    // Two-wire write frame of three bytes; a[2:0] return the ack levels seen
    task automatic i2c_frame(input logic [23:0] s, output logic [7:0] a);
        @(posedge core_clk_i);
        #1;
        a = 8'hFF;
        d_o = 8'h07; // Clock, data and ack wire idle high
        #40 d_o[1] = 1'b0; // Start
        #40 d_o[0] = 1'b0;
        for (int k = 2; k >= 0; k--) begin
            for (int i = 8; i >= 0; i--) begin
                // Data moves only while the clock is low; ninth bit released
                d_o[1] = (i == 0) ? 1'b1 : s[8 * k + (i + 7) % 8];
                #40 d_o[0] = 1'b1;
                #40 a[k] = bus_i[2];
                d_o[0] = 1'b0;
            end
        end
        d_o[1] = 1'b0;
        #40 d_o[0] = 1'b1;
        #40 d_o[1] = 1'b1; // Stop
    endtask
endmodule

// File: dv/tb_dhi_host_port.sv
// Self-checking bench of the display host port in parallel, serial and two-wire modes
`timescale 1ns/1ps
`define CHK(g, x) begin tests_run++; if ((g) !== (x)) begin errors++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x); end end
module tb_dhi_host_port;
    logic core_clk, rst_n, ser_clk, cs_n, e, rw, dc, cmd_wr, ram_wr, form;
    logic [1:0] mode;
    logic [7:0] status, rdd, hd, bus, dd, doe, wrb, ram_addr, col, q;
    int errors = 0;
    int tests_run = 0;
    int n_cmd = 0;
    int n_ram = 0;
    // Shared pins: port output wins while enabled, link clock on bit 0
    assign bus = (dd & doe) | (hd & ~doe) | {7'h00, ser_clk};
    dhi_host_model u_host (.core_clk_i(core_clk), .bus_i(bus), .cs_n_o(cs_n), .e_o(e),
        .rw_o(rw), .dc_o(dc), .d_o(hd), .ser_clk_o(ser_clk));
    dhi_host_port u_dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .ser_clk_i(ser_clk),
        .bus_mode_i(mode), .cs_latch_form_i(form), .cs_n_i(cs_n), .e_rd_n_i(e),
        .rw_wr_n_i(rw), .dc_i(dc), .d_i(bus), .d_o(dd), .d_oe_o(doe), .status_i(status),
        .ram_rd_data_i(rdd), .wr_byte_o(wrb), .cmd_wr_o(cmd_wr), .ram_wr_o(ram_wr),
        .ram_addr_o(ram_addr), .col_addr_o(col));
    // ==========================================================
    // Clock and delivery counters
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        n_cmd += int'(cmd_wr === 1'b1);
        n_ram += int'(ram_wr === 1'b1);
    end
    // ==========================================================
    // Tasks: reset with a new strap, one access of three phases
    task automatic rst(input logic [1:0] m);
        @(posedge core_clk);
        #1;
        rst_n = 1'b0;
        mode = m;
        repeat (2) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        repeat (6) @(posedge core_clk);
    endtask
    // Pattern p holds strobe levels {e, rw} of phase one then phase two
    task automatic acc(input logic [3:0] p, input logic dc_v, input logic [7:0] d);
        logic [7:0] t;
        u_host.step(1'b0, p[3], p[2], dc_v, d, q);
        u_host.step(1'b0, p[1], p[0], dc_v, d, t);
        u_host.step(1'b1, p[1], p[0], dc_v, d, t);
    endtask
    task automatic give_verdict();
        $display("Counts: %0d checks, %0d mismatches", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Watchdog: run needs about 550 cycles
    initial begin
        #60us;
        errors++;
        give_verdict();
    end
    // ==========================================================
    // Tests
    initial begin
        rst_n = 1'b0;
        form = 1'b0;
        mode = dhi_pkg::DHI_MODE_6800;
        status = 8'hA5;
        rdd = 8'h11;
        rst(dhi_pkg::DHI_MODE_6800);
        `CHK(col, 8'h00)
        u_host.step(1'b1, 1'b1, 1'b0, 1'b0, 8'h77, q);
        u_host.step(1'b1, 1'b0, 1'b0, 1'b0, 8'h77, q);
        `CHK(n_cmd, 0)
        acc(4'h8, 1'b0, 8'h81);
        `CHK(n_cmd, 1)
        `CHK(wrb, 8'h81)
        acc(4'h8, 1'b1, 8'h5A);
        acc(4'h8, 1'b1, 8'hA6);
        `CHK(n_ram, 2)
        `CHK(ram_addr, 8'h01)
        `CHK(col, 8'h02)
        acc(4'hD, 1'b0, 8'h00);
        `CHK(q, 8'hA5)
        acc(4'hD, 1'b1, 8'h00); // Dummy read primes the pipeline
        rdd = 8'h22;
        acc(4'hD, 1'b1, 8'h00);
        `CHK(q, 8'h11)
        $display("test 6800 done");
        rst(dhi_pkg::DHI_MODE_8080);
        `CHK(col, 8'h00)
        u_host.step(1'b1, 1'b1, 1'b1, 1'b0, 8'h00, q);
        acc(4'hB, 1'b1, 8'hC3);
        `CHK(n_ram, 3)
        `CHK(ram_addr, 8'h00)
        acc(4'h7, 1'b0, 8'h00);
        `CHK(q, 8'hA5)
        form = 1'b1;
        rst(dhi_pkg::DHI_MODE_8080);
        acc(4'hA, 1'b1, 8'h3C);
        `CHK(n_ram, 4)
        `CHK(wrb, 8'h3C)
        $display("test 8080 done");
        rst(dhi_pkg::DHI_MODE_SER);
        u_host.step(1'b1, 1'b0, 1'b0, 1'b0, 8'h00, q);
        u_host.ser_byte(1'b1, 8'h96);
        repeat (8) @(posedge core_clk);
        `CHK(n_ram, 5)
        `CHK(wrb, 8'h96)
        u_host.ser_byte(1'b0, 8'h2D);
        repeat (8) @(posedge core_clk);
        `CHK(n_cmd, 2)
        `CHK(wrb, 8'h2D)
        $display("test serial done");
        rst(dhi_pkg::DHI_MODE_I2C);
        u_host.i2c_frame({8'h78, 8'h40, 8'hE7}, q);
        `CHK(q[2:0], 3'h0)
        repeat (8) @(posedge core_clk);
        `CHK(n_ram, 6)
        `CHK(wrb, 8'hE7)
        `CHK(ram_addr, 8'h00)
        $display("test two-wire done");
        give_verdict();
    end
endmodule
